// >>> design/csr_consts.svh
// Holds bit positions, masks, reset values and addresses of the status word.
// Assumes it is included by its bare name from the package and the modules.
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH

// ----------------------------------------------------------------------
// System-register address
// ----------------------------------------------------------------------
`define CSR_SYSREG_ADDR     8'h00

// ----------------------------------------------------------------------
// Lower halfword bit positions
// ----------------------------------------------------------------------
`define CSR_BIT_CARRY       0
`define CSR_BIT_ZERO        1
`define CSR_BIT_NEG         2
`define CSR_BIT_OVF         3
`define CSR_BIT_SAT         4
`define CSR_BIT_LOCK        5
`define CSR_BIT_SCRATCH     14

// ----------------------------------------------------------------------
// Upper halfword bit positions
// ----------------------------------------------------------------------
`define CSR_BIT_GLOBAL      16
`define CSR_BIT_LVL0        17
`define CSR_BIT_LVL3        20
`define CSR_BIT_EXC         21
`define CSR_BIT_MODE_LO     22
`define CSR_BIT_MODE_HI     24
`define CSR_BIT_DEBUG       26
`define CSR_BIT_DBGMASK     27
`define CSR_BIT_SECURE      31

// ----------------------------------------------------------------------
// Masks and reset value
// ----------------------------------------------------------------------
`define CSR_LOW_MASK        32'h0000_ffff
`define CSR_IMPL_MASK       32'h8dff_403f
`define CSR_WRITE_MASK      32'h0dff_403f
`define CSR_RESET_WORD      32'h0061_0000
`define CSR_ARCH_SECURE_REV 3

`endif

// >>> design/csr_pkg.sv
// Holds the types shared by the status-word modules.
// Assumes csr_consts.svh is on the include path.
package csr_pkg;
  `include "csr_consts.svh"

  // Execution mode codes of the three-bit mode field.
  typedef enum logic [2:0] {
    CSR_MODE_APP  = 3'h0,
    CSR_MODE_SUP  = 3'h1,
    CSR_MODE_INT0 = 3'h2,
    CSR_MODE_INT1 = 3'h3,
    CSR_MODE_INT2 = 3'h4,
    CSR_MODE_INT3 = 3'h5,
    CSR_MODE_EXC  = 3'h6,
    CSR_MODE_NMI  = 3'h7
  } csr_mode_e;

  // Arithmetic flag group: carry, zero, negative, overflow.
  typedef logic [3:0] csr_flags_t;
endpackage

// >>> design/csr_flag_if.sv
// Carries arithmetic flag updates from the flag unit to the status word.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface csr_flag_if;
  import csr_pkg::*;
  csr_flags_t update;
  csr_flags_t value;
  logic       satHit;

  modport producer (output update, output value, output satHit);
  modport consumer (input update, input value, input satHit);
endinterface

// >>> design/csr_flag_unit.sv
// Holds the flag unit that turns an execution result into flag updates.
// Assumes result, carry and overflow come from the core's ALU, same clock.
`timescale 1ns/1ps
`include "csr_consts.svh"
module csr_flag_unit
  import csr_pkg::*;
(
  input  wire logic       aluValid,
  input  wire csr_flags_t aluUpdate,
  input  wire logic [31:0] aluResult,
  input  wire logic       aluCarry,
  input  wire logic       aluOverflow,
  input  wire logic       aluSatOverflow,
  csr_flag_if.producer    flagBus
);
  import csr_pkg::*;

  // Zero test of a result word.
  function automatic logic isZero(input logic [31:0] word);
    isZero = (word == 32'h0000_0000);
  endfunction

  // -------------------------------------------------------------------
  // Flag values
  // -------------------------------------------------------------------
  // Each instruction chooses which flags it touches through aluUpdate.
  always_comb begin
    flagBus.update = aluValid ? aluUpdate : 4'h0;
    flagBus.value[`CSR_BIT_CARRY] = aluCarry;
    flagBus.value[`CSR_BIT_ZERO]  = isZero(aluResult);
    flagBus.value[`CSR_BIT_NEG]   = aluResult[31];
    flagBus.value[`CSR_BIT_OVF]   = aluOverflow;
    flagBus.satHit = aluValid & aluSatOverflow;
  end
endmodule

// >>> design/csr_status_word.sv
// Holds the processor status word with its automatic hardware updates.
// Assumes the pipeline presents at most one instruction effect per cycle
// and that system-register moves target address zero when selected here.
`timescale 1ns/1ps
`include "csr_consts.svh"

// Behaviour
// - Word splits in halves; upper half reachable only in privileged modes.
// - Carry, zero, negative, overflow, saturation, lock, scratch live in lower half.
// - Secure bit shows secure execution, only on revision 3 and later, otherwise zero.
// - Debug mask set refuses debug entry; cleared at reset, freely writable.
// - Debug flag set in debug state, cleared at reset; changed by debug paths.
// - Three-bit mode field encodes the eight execution modes.
// - Reset leaves the mode field at supervisor.
// - Mode changes on interrupt, exception, supervisor call and returns.
// - Exception mask blocks exceptions; set at reset, exception and debug entry.
// - A level is accepted only when its mask and global mask are clear.
// - Starting level k service sets masks of level k and all below.
// - Global mask blocks all; set on reset, exception, debug, trap; cleared on trap return.
// - Scratch flag changes only by software and debug return; cleared at reset.
// - Lock flag serves conditional store; cleared by exception return and reset.
// - Saturation flag is sticky until cleared by the clear-flag instruction, a move or debug return.
// - Overflow flag follows arithmetic overflow.
// - Negative flag follows arithmetic and logical results.
// - Zero flag set on zero result, cleared otherwise.
// - Carry flag follows arithmetic carry.
// - Word reachable only by system-register moves at address zero and by flag set/clear instructions.
module csr_status_word
  import csr_pkg::*;
#(
  parameter int unsigned ARCH_REV     = 3,
  parameter logic        SECURE_RESET = 1'b0
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              srRdEn,
  input  wire logic              srWrEn,
  input  wire logic [7:0]        srAddr,
  input  wire logic [31:0]       srWrData,
  output logic      [31:0]       srRdData,
  input  wire logic              flagSetEn,
  input  wire logic              flagClrEn,
  input  wire logic [4:0]        flagIdx,
  input  wire logic              aluValid,
  input  wire csr_pkg::csr_flags_t aluUpdate,
  input  wire logic [31:0]       aluResult,
  input  wire logic              aluCarry,
  input  wire logic              aluOverflow,
  input  wire logic              aluSatOverflow,
  input  wire logic              irqStart,
  input  wire logic [1:0]        irqLevel,
  input  wire logic              nmiStart,
  input  wire logic              excStart,
  input  wire logic              debugReq,
  input  wire logic              debugReturn,
  input  wire logic [31:0]       debugReturnWord,
  input  wire logic              scallExec,
  input  wire logic              retsExec,
  input  wire logic              reteExec,
  input  wire csr_pkg::csr_mode_e returnMode,
  input  wire logic              trapEnter,
  input  wire logic              trapReturn,
  input  wire logic              secureEnter,
  input  wire logic              secureExit,
  output logic      [31:0]       srWord,
  output csr_pkg::csr_mode_e     modeOut,
  output logic                   privileged,
  output logic      [3:0]        irqEnable,
  output logic                   excEnable,
  output logic                   debugAccept,
  output logic                   debugState,
  output logic                   lockFlag
);
  import csr_pkg::*;

  // -------------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------------
  logic       rstMeta;
  logic       rstSync;

  // Two flops release the asynchronous reset in step with the clock.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  csr_flags_t arith;
  logic       satFlag;
  logic       scratchFlag;
  csr_mode_e  mode;
  logic       excMask;
  logic [3:0] lvlMask;
  logic       globalMask;
  logic       dbgFlag;
  logic       dbgMask;
  logic       secureFlag;

  csr_flag_if flagBus ();

  csr_flag_unit u_flag (
    .aluValid       (aluValid),
    .aluUpdate      (aluUpdate),
    .aluResult      (aluResult),
    .aluCarry       (aluCarry),
    .aluOverflow    (aluOverflow),
    .aluSatOverflow (aluSatOverflow),
    .flagBus        (flagBus.producer)
  );

  // Builds a one-hot word from a bit index.
  function automatic logic [31:0] bitSel(input logic [4:0] idx);
    bitSel = 32'h0000_0001 << idx;
  endfunction

  // -------------------------------------------------------------------
  // Access decode
  // -------------------------------------------------------------------
  logic        sel;
  logic [31:0] accMask;
  logic [31:0] wrBits;
  logic [31:0] setBits;
  logic [31:0] clrBits;
  logic        dbgEntry;
  logic        secureImpl;

  // Moves hit the word only at its own address; upper half needs privilege.
  always_comb begin
    privileged = (mode != CSR_MODE_APP);
    sel        = (srAddr == `CSR_SYSREG_ADDR);
    accMask    = privileged ? `CSR_WRITE_MASK
                            : (`CSR_WRITE_MASK & `CSR_LOW_MASK);
    wrBits     = (srWrEn && sel) ? accMask : 32'h0000_0000;
    setBits    = flagSetEn ? (bitSel(flagIdx) & accMask) : 32'h0000_0000;
    clrBits    = flagClrEn ? (bitSel(flagIdx) & accMask) : 32'h0000_0000;
    secureImpl = (ARCH_REV >= `CSR_ARCH_SECURE_REV);
  end

  // Debug entry is refused while masked or already in debug state.
  assign debugAccept = debugReq & ~dbgMask & ~dbgFlag;
  assign dbgEntry    = debugAccept;

  // -------------------------------------------------------------------
  // Arithmetic flags
  // -------------------------------------------------------------------
  csr_flags_t next_arith;

  // Debug return restores, then moves, then flag instructions, then ALU.
  always_comb begin
    next_arith = arith;
    for (int i = 0; i < 4; i++) begin
      if (debugReturn) begin
        next_arith[i] = debugReturnWord[i];
      end else if (wrBits[i]) begin
        next_arith[i] = srWrData[i];
      end else if (setBits[i]) begin
        next_arith[i] = 1'b1;
      end else if (clrBits[i]) begin
        next_arith[i] = 1'b0;
      end else if (flagBus.update[i]) begin
        next_arith[i] = flagBus.value[i];
      end
    end
  end

  // Arithmetic flags clear at reset.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      arith <= 4'h0;
    end else begin
      arith <= next_arith;
    end
  end

  // Saturation is sticky; a new overflow wins over a same-cycle clear.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      satFlag <= 1'b0;
    end else if (flagBus.satHit || setBits[`CSR_BIT_SAT]) begin
      satFlag <= 1'b1;
    end else if (debugReturn) begin
      satFlag <= debugReturnWord[`CSR_BIT_SAT];
    end else if (wrBits[`CSR_BIT_SAT]) begin
      satFlag <= srWrData[`CSR_BIT_SAT];
    end else if (clrBits[`CSR_BIT_SAT]) begin
      satFlag <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Lock and scratch
  // -------------------------------------------------------------------
  // Lock is cleared by exception return; software arms it otherwise.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      lockFlag <= 1'b0;
    end else if (reteExec) begin
      lockFlag <= 1'b0;
    end else if (debugReturn) begin
      lockFlag <= debugReturnWord[`CSR_BIT_LOCK];
    end else if (wrBits[`CSR_BIT_LOCK]) begin
      lockFlag <= srWrData[`CSR_BIT_LOCK];
    end else if (setBits[`CSR_BIT_LOCK]) begin
      lockFlag <= 1'b1;
    end else if (clrBits[`CSR_BIT_LOCK]) begin
      lockFlag <= 1'b0;
    end
  end

  // Scratch changes only by explicit software access and debug return.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      scratchFlag <= 1'b0;
    end else if (wrBits[`CSR_BIT_SCRATCH]) begin
      scratchFlag <= srWrData[`CSR_BIT_SCRATCH];
    end else if (setBits[`CSR_BIT_SCRATCH]) begin
      scratchFlag <= 1'b1;
    end else if (clrBits[`CSR_BIT_SCRATCH]) begin
      scratchFlag <= 1'b0;
    end else if (debugReturn) begin
      scratchFlag <= debugReturnWord[`CSR_BIT_SCRATCH];
    end
  end

  // -------------------------------------------------------------------
  // Execution mode
  // -------------------------------------------------------------------
  csr_mode_e next_mode;

  // Event entry outranks instruction-driven mode changes.
  always_comb begin
    next_mode = mode;
    if (nmiStart) begin
      next_mode = CSR_MODE_NMI;
    end else if (excStart) begin
      next_mode = CSR_MODE_EXC;
    end else if (irqStart) begin
      next_mode = csr_mode_e'(3'(irqLevel) + 3'h2);
    end else if (scallExec) begin
      next_mode = CSR_MODE_SUP;
    end else if (retsExec || reteExec) begin
      next_mode = returnMode;
    end else if (debugReturn) begin
      next_mode = csr_mode_e'(debugReturnWord[`CSR_BIT_MODE_HI:`CSR_BIT_MODE_LO]);
    end else if (wrBits[`CSR_BIT_MODE_LO]) begin
      next_mode = csr_mode_e'(srWrData[`CSR_BIT_MODE_HI:`CSR_BIT_MODE_LO]);
    end
  end

  // Mode starts in supervisor after reset.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      mode <= CSR_MODE_SUP;
    end else begin
      mode <= next_mode;
    end
  end

  // -------------------------------------------------------------------
  // Exception and interrupt masks
  // -------------------------------------------------------------------
  // Exception mask is raised by exception start and debug entry.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      excMask <= 1'b1;
    end else if (excStart || dbgEntry) begin
      excMask <= 1'b1;
    end else if (debugReturn) begin
      excMask <= debugReturnWord[`CSR_BIT_EXC];
    end else if (wrBits[`CSR_BIT_EXC]) begin
      excMask <= srWrData[`CSR_BIT_EXC];
    end else if (setBits[`CSR_BIT_EXC]) begin
      excMask <= 1'b1;
    end else if (clrBits[`CSR_BIT_EXC]) begin
      excMask <= 1'b0;
    end
  end

  logic [3:0] next_lvlMask;

  // Serving level k masks k and every lower level; software may reopen.
  always_comb begin
    next_lvlMask = lvlMask;
    for (int i = 0; i < 4; i++) begin
      if (irqStart && (2'(i) <= irqLevel)) begin
        next_lvlMask[i] = 1'b1;
      end else if (debugReturn) begin
        next_lvlMask[i] = debugReturnWord[`CSR_BIT_LVL0 + i];
      end else if (wrBits[`CSR_BIT_LVL0 + i]) begin
        next_lvlMask[i] = srWrData[`CSR_BIT_LVL0 + i];
      end else if (setBits[`CSR_BIT_LVL0 + i]) begin
        next_lvlMask[i] = 1'b1;
      end else if (clrBits[`CSR_BIT_LVL0 + i]) begin
        next_lvlMask[i] = 1'b0;
      end
    end
  end

  // Level masks clear at reset.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      lvlMask <= 4'h0;
    end else begin
      lvlMask <= next_lvlMask;
    end
  end

  // Global mask is raised by exception, debug entry and trap, lowered by trap return.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      globalMask <= 1'b1;
    end else if (excStart || dbgEntry || trapEnter) begin
      globalMask <= 1'b1;
    end else if (trapReturn) begin
      globalMask <= 1'b0;
    end else if (debugReturn) begin
      globalMask <= debugReturnWord[`CSR_BIT_GLOBAL];
    end else if (wrBits[`CSR_BIT_GLOBAL]) begin
      globalMask <= srWrData[`CSR_BIT_GLOBAL];
    end else if (setBits[`CSR_BIT_GLOBAL]) begin
      globalMask <= 1'b1;
    end else if (clrBits[`CSR_BIT_GLOBAL]) begin
      globalMask <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Debug and secure state
  // -------------------------------------------------------------------
  // Debug flag follows entry and return; other writes are not protected.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      dbgFlag <= 1'b0;
    end else if (dbgEntry) begin
      dbgFlag <= 1'b1;
    end else if (debugReturn) begin
      dbgFlag <= 1'b0;
    end else if (wrBits[`CSR_BIT_DEBUG]) begin
      dbgFlag <= srWrData[`CSR_BIT_DEBUG];
    end
  end

  // Debug mask is plain software state.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      dbgMask <= 1'b0;
    end else if (wrBits[`CSR_BIT_DBGMASK]) begin
      dbgMask <= srWrData[`CSR_BIT_DBGMASK];
    end else if (setBits[`CSR_BIT_DBGMASK]) begin
      dbgMask <= 1'b1;
    end else if (clrBits[`CSR_BIT_DBGMASK]) begin
      dbgMask <= 1'b0;
    end
  end

  // Secure bit exists only on revisions with secure support.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      secureFlag <= SECURE_RESET;
    end else if (secureEnter) begin
      secureFlag <= 1'b1;
    end else if (secureExit) begin
      secureFlag <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Word assembly and outputs
  // -------------------------------------------------------------------
  // Reserved positions stay zero because only implemented bits are placed.
  always_comb begin
    srWord = 32'h0000_0000;
    srWord[`CSR_BIT_OVF:`CSR_BIT_CARRY]    = arith;
    srWord[`CSR_BIT_SAT]                   = satFlag;
    srWord[`CSR_BIT_LOCK]                  = lockFlag;
    srWord[`CSR_BIT_SCRATCH]               = scratchFlag;
    srWord[`CSR_BIT_GLOBAL]                = globalMask;
    srWord[`CSR_BIT_LVL3:`CSR_BIT_LVL0]    = lvlMask;
    srWord[`CSR_BIT_EXC]                   = excMask;
    srWord[`CSR_BIT_MODE_HI:`CSR_BIT_MODE_LO] = mode;
    srWord[`CSR_BIT_DEBUG]                 = dbgFlag;
    srWord[`CSR_BIT_DBGMASK]               = dbgMask;
    srWord[`CSR_BIT_SECURE]                = secureImpl & secureFlag;
  end

  // Acceptance gates for the interrupt controller and exception logic.
  always_comb begin
    irqEnable  = ~lvlMask & {4{~globalMask}};
    excEnable  = ~excMask;
    modeOut    = mode;
    debugState = dbgFlag;
  end

  // Read data is registered; unprivileged reads see only the low half.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      srRdData <= 32'h0000_0000;
    end else if (srRdEn && sel) begin
      srRdData <= privileged ? srWord : (srWord & `CSR_LOW_MASK);
    end else if (srRdEn) begin
      srRdData <= 32'h0000_0000;
    end
  end
endmodule

// >>> sim/csr_status_word_asserts.sv
// Checker for the status word top ports.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "csr_consts.svh"
module csr_status_word_chk
  import csr_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               nrst,
  input wire logic               srRdEn,
  input wire logic               srWrEn,
  input wire logic [7:0]         srAddr,
  input wire logic [31:0]        srRdData,
  input wire logic               flagClrEn,
  input wire logic               irqStart,
  input wire logic [1:0]         irqLevel,
  input wire logic               nmiStart,
  input wire logic               excStart,
  input wire logic               debugReturn,
  input wire logic               reteExec,
  input wire logic [31:0]        srWord,
  input wire csr_pkg::csr_mode_e modeOut,
  input wire logic               privileged,
  input wire logic [3:0]         irqEnable,
  input wire logic               debugAccept,
  input wire logic               debugState,
  input wire logic               lockFlag
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  // All checks share the core clock and are idle in reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  rd_other_a: assert property (srRdEn && srAddr != `CSR_SYSREG_ADDR |=> srRdData == 0)
    else $error("Read of another address returned data.");
  rd_unpriv_a: assert property (srRdEn && !privileged |=> srRdData[31:16] == 16'h0)
    else $error("Unprivileged read showed the upper half.");
  resv_zero_a: assert property ((srWord & ~`CSR_IMPL_MASK) == 32'h0)
    else $error("Reserved bit set.");
  irq_gate_a: assert property (irqEnable == (~srWord[20:17] & {4{~srWord[16]}}))
    else $error("Level enables disagree with masks.");
  dbg_block_a: assert property (srWord[27] |-> !debugAccept)
    else $error("Debug entry accepted while masked.");
  dbg_entry_a: assert property (debugAccept |=> debugState && srWord[21] && srWord[16])
    else $error("Debug entry did not set flag and masks.");
  exc_entry_a: assert property (excStart && !nmiStart |=>
    modeOut == CSR_MODE_EXC && srWord[21] && srWord[16]) else $error("Bad exception entry.");
  irq_entry_a: assert property (irqStart && !excStart && !nmiStart |=>
    modeOut == $past(irqLevel) + 3'h2 && srWord[17 + $past(irqLevel)] && srWord[17])
    else $error("Bad interrupt entry.");
  lock_clr_a: assert property (reteExec |=> !lockFlag)
    else $error("Lock survived exception return.");
  sat_keep_a: assert property (srWord[4] && !srWrEn && !flagClrEn && !debugReturn |=> srWord[4])
    else $error("Saturation flag dropped by itself.");

  cover property (irqStart);
  cover property (debugAccept);
  cover property (excStart ##2 reteExec);
endmodule

bind csr_status_word csr_status_word_chk i_csr_status_word_chk (.core_clk, .nrst, .srRdEn,
  .srWrEn, .srAddr, .srRdData, .flagClrEn, .irqStart, .irqLevel, .nmiStart, .excStart,
  .debugReturn, .reteExec, .srWord, .modeOut, .privileged, .irqEnable, .debugAccept,
  .debugState, .lockFlag);

// >>> sim/csr_status_word_tb.sv
// Self-checking bench for the status word: moves, flag ops and events.
// Assumes design files and checker are compiled first.
`timescale 1ns/1ps
`include "csr_consts.svh"
module csr_status_word_tb;
  import csr_pkg::*;
  localparam logic [13:0] W = 14'h1, R = 14'h2, FS = 14'h4, FC = 14'h8, IQ = 14'h10;
  localparam logic [13:0] EX = 14'h20, SC = 14'h40, RE = 14'h80, DR = 14'h100;
  localparam logic [13:0] TR = 14'h200, TE = 14'h400, SE = 14'h800, AV = 14'h1000;
  localparam logic [13:0] DQ = 14'h2000;
  localparam logic [31:0] RST = `CSR_RESET_WORD;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [13:0] ctl = '0;
  logic [31:0] wd = '0;
  logic [2:0]  a3 = '0;
  logic [7:0]  ad = '0;
  logic [31:0] srRdData, srWord;
  csr_mode_e   modeOut;
  logic [3:0]  irqEnable;
  logic        privileged, excEnable, debugAccept, debugState, lockFlag;
  int          miscompares = 0;
  int          n_checks = 0;

  // Shared data word feeds every data input but srAddr, the ALU carry, overflow and saturation bits, aluUpdate and returnMode; only enabled paths sample it.
  csr_status_word i_csr_status_word (.core_clk, .nrst, .srWrEn(ctl[0]), .srRdEn(ctl[1]),
    .srAddr(ad), .srWrData(wd), .srRdData, .flagSetEn(ctl[2]), .flagClrEn(ctl[3]),
    .flagIdx(wd[4:0]), .aluValid(ctl[12]), .aluUpdate(4'hf), .aluResult(wd),
    .aluCarry(a3[2]), .aluOverflow(a3[1]), .aluSatOverflow(a3[0]), .irqStart(ctl[4]),
    .irqLevel(wd[1:0]), .nmiStart(1'b0), .excStart(ctl[5]), .debugReq(ctl[13]),
    .debugReturn(ctl[8]), .debugReturnWord(wd), .scallExec(ctl[6]), .retsExec(1'b0),
    .reteExec(ctl[7]), .returnMode(CSR_MODE_SUP), .trapEnter(ctl[10]),
    .trapReturn(ctl[9]), .secureEnter(ctl[11]), .secureExit(1'b0), .srWord, .modeOut,
    .privileged, .irqEnable, .excEnable, .debugAccept, .debugState, .lockFlag);

  // Clock toggles every half period of 8 ns.
  always #4 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle request, then the word is compared once it has settled.
  task automatic op(input logic [13:0] c, input logic [31:0] d, input logic [31:0] exp,
                    input logic [2:0] f = 3'h0, input logic [7:0] a = 8'h00);
    @(posedge core_clk);
    ctl <= c;
    wd <= d;
    a3 <= f;
    ad <= a;
    @(posedge core_clk);
    ctl <= '0;
    #1 chk(srWord, exp);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk(srWord, RST);
    op(R, 0, RST);
    chk(srRdData, RST);
    op(R, 0, RST, 3'h0, 8'h04);
    chk(srRdData, 0);
    op(W, 32'hf03f_ffff, 32'h003f_403f);
    chk({31'h0, privileged}, 0);
    op(W | R, 0, 32'h003f_0000);
    chk(srRdData, 32'h0000_403f);
    op(SC, 0, 32'h007f_0000);
    op(W, 32'h0040_0020, 32'h0040_0020);
    chk({irqEnable, excEnable}, 5'h1f);
    op(IQ, 32'h2, 32'h010e_0020);
    chk({irqEnable, excEnable}, 5'h11);
    op(EX, 0, 32'h01af_0020);
    op(RE, 0, 32'h006f_0000);
    op(TR, 0, 32'h006e_0000);
    op(TE, 0, 32'h006f_0000);
    op(W, 32'h0840_0000, 32'h0840_0000);
    op(DQ, 0, 32'h0840_0000);
    op(W, 32'h0040_0000, 32'h0040_0000);
    op(DQ, 0, 32'h0461_0000);
    op(DR, 32'h0040_0000, 32'h0040_0000);
    op(AV, 0, 32'h0040_001b, 3'h7);
    op(AV, 32'h8000_0000, 32'h0040_0014);
    op(FC, 32'h4, 32'h0040_0004);
    op(FS, 32'he, 32'h0040_4004);
    op(SE, 0, 32'h8040_4004);
    op(FS, 32'h1b, 32'h8840_4004);
    tally_and_finish();
  end
endmodule
